//--- design/isu_core.sv
/*
 Special function register unit of a small 8-bit core: indirect ports, memory pointers,
 extended direct addressing, bank select, accumulator, PC low byte and table read.
 Assumes an AHB-Lite master issuing single word transfers; program memory is a table
 input port; the unit's data memory is held here as an array.
*/
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "isu_defines.svh"
// Functional notes
// - Accessing an indirect port acts on the data memory location its pointer holds, never on the port.
// - The sector-0 port with its one-byte pointer reaches sector 0 only.
// - The wide ports take sector from the pointer high byte and location from the low byte.
// - An indirect access that lands on an indirect port reads zero and writes nothing.
// - All five pointer bytes are real memory cells, readable, writable and steppable.
// - Extended direct addresses use the upper part as sector and the low eight bits as location.
// - A jump lands at its target within the bank chosen by the bank bits.
// - Four-bank variant: two bank bits encode the bank directly and reset to zero.
// - Two-bank variant: only bit 0 exists, the upper bits read zero, it resets to zero.
// - ALU results come through the accumulator; no register-to-register path exists.
// - Writing the PC low byte replaces only its low eight bits.
// - A PC low byte write costs one extra dummy cycle.
// - A table read puts the high byte in the table result register and the low byte at the named sector-0 cell, unless that cell lies in the special area.
module isu_core #(
	parameter int SECTORS = 2,
	parameter int BANKS = 4,
	parameter int PAGE_BITS = 8,
	parameter int PC_BITS = 13
)(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [15:0] TABLE_ADDR,
	input wire logic [15:0] TABLE_WORD,
	output logic [PC_BITS-1:0] PC_OUT,
	output logic BUSY
);
	localparam int BB = (BANKS == 4) ? 2 : 1;
	localparam int DEPTH = SECTORS * 256;
	initial
	begin
		if (!(BANKS == 2 || BANKS == 4) || SECTORS < 1 || SECTORS > 256 || PC_BITS <= PAGE_BITS + BB)
			$error("isu_core: unsupported parameters");
	end

	logic [7:0] mem_q [DEPTH];
	logic [7:0] acc_q;
	logic [7:0] tres_q;
	logic [7:0] bank_q;
	logic [PC_BITS-1:0] pc_q;
	logic [7:0] rdat_q;
	isu_pkg::isu_state_t state_q;
	isu_pkg::isu_aph_t aph_q;
	logic [31:0] rdata_q;

	// Address phase capture; only one wait-free data phase, so HREADYOUT stays high
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			aph_q <= '0;
		else if (HREADY)
			aph_q <= '{bus_ph: (HSEL ? HTRANS : 2'h0), addr: HADDR[11:0], wr: HWRITE};
	end
	wire logic wr_go = (aph_q.bus_ph == `ISU_HTRANS_NONSEQ) && aph_q.wr;
	wire logic rd_go = HSEL && HREADY && (HTRANS == `ISU_HTRANS_NONSEQ) && !HWRITE;
	isu_pkg::isu_cmd_t cmd;
	assign cmd = HWDATA;
	wire logic cmd_go = wr_go && (aph_q.addr == `ISU_R_CMD) && (state_q == isu_pkg::ISU_ST_IDLE);

	// Effective address resolution
	logic [7:0] sec_e;
	logic [7:0] loc_e;
	logic via_ind;
	logic [7:0] sp_loc;
	assign sp_loc = cmd.addr;
	always_comb
	begin
		sec_e = cmd.sector;
		loc_e = cmd.addr;
		via_ind = 1'b0;
		if (cmd.op != isu_pkg::ISU_OP_LRD && cmd.op != isu_pkg::ISU_OP_LWR)
			sec_e = 8'h00;
		if (sp_loc == `ISU_A_IND0)
		begin
			sec_e = 8'h00;
			loc_e = mem_q[`ISU_A_PTR0];
			via_ind = 1'b1;
		end
		else if (sp_loc == `ISU_A_IND1)
		begin
			sec_e = mem_q[`ISU_A_PTR1S];
			loc_e = mem_q[`ISU_A_PTR1L];
			via_ind = 1'b1;
		end
		else if (sp_loc == `ISU_A_IND2)
		begin
			sec_e = mem_q[`ISU_A_PTR2S];
			loc_e = mem_q[`ISU_A_PTR2L];
			via_ind = 1'b1;
		end
	end
	// extended form: sector field is the upper part, location the low eight bits
	wire logic [15:0] eff = {sec_e, loc_e};
	wire logic sec_ok = ({8'h00, sec_e} < 16'(SECTORS));
	wire logic [15:0] idx = sec_ok ? eff : 16'h0000;
	// an indirect hit on an indirect port
	wire logic ind_on_ind = via_ind && (loc_e == `ISU_A_IND0 || loc_e == `ISU_A_IND1 || loc_e == `ISU_A_IND2);
	wire logic is_spec = (loc_e < `ISU_SPECIAL_TOP);

	logic [7:0] rd_val;
	always_comb
	begin
		rd_val = mem_q[idx[$clog2(DEPTH)-1:0]];
		if (ind_on_ind || !sec_ok)
			rd_val = `ISU_IND_READ;
		else if (is_spec && loc_e == `ISU_A_ACC)
			rd_val = acc_q;
		else if (is_spec && loc_e == `ISU_A_PCLB)
			rd_val = pc_q[7:0];
		else if (is_spec && loc_e == `ISU_A_TRES)
			rd_val = tres_q;
		else if (is_spec && loc_e == `ISU_A_BANK)
			rd_val = bank_q;
	end
	wire logic [7:0] bank_mask = (BANKS == 4) ? `ISU_BANK4_MASK : `ISU_BANK2_MASK;

	// Value to store: accumulator for writes, stepped cell for inc/dec
	logic [7:0] wval;
	logic do_store;
	always_comb
	begin
		wval = acc_q;
		do_store = 1'b0;
		case (cmd.op)
			isu_pkg::ISU_OP_WR, isu_pkg::ISU_OP_LWR: do_store = 1'b1;
			isu_pkg::ISU_OP_INC:
			begin
				wval = rd_val + 8'h01;
				do_store = 1'b1;
			end
			isu_pkg::ISU_OP_DEC:
			begin
				wval = rd_val - 8'h01;
				do_store = 1'b1;
			end
			default: do_store = 1'b0;
		endcase
		if (ind_on_ind || !sec_ok)
			do_store = 1'b0;
	end
	wire logic pcl_wr = cmd_go && do_store && is_spec && loc_e == `ISU_A_PCLB;
	wire logic bank_wr = cmd_go && do_store && is_spec && loc_e == `ISU_A_BANK;

	// Data memory: pointers and table pointers live here as ordinary cells
	wire logic [15:0] tbl_idx = cmd.addr == `ISU_A_TRES ? 16'h0000 : {8'h00, cmd.addr};
	always_ff @(posedge REF_CLK)
	begin
		if (cmd_go && do_store && !(is_spec && (loc_e == `ISU_A_ACC || loc_e == `ISU_A_PCLB
			|| loc_e == `ISU_A_TRES || loc_e == `ISU_A_BANK)))
			mem_q[idx[$clog2(DEPTH)-1:0]] <= wval;
		else if (cmd_go && cmd.op == isu_pkg::ISU_OP_TRD && cmd.addr >= `ISU_SPECIAL_TOP)
			mem_q[tbl_idx[$clog2(DEPTH)-1:0]] <= TABLE_WORD[7:0];
	end

	// Accumulator: loaded by reads and by ALU results
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			acc_q <= 8'h00;
		else if (cmd_go && (cmd.op == isu_pkg::ISU_OP_RD || cmd.op == isu_pkg::ISU_OP_LRD))
			acc_q <= rd_val;
		else if (cmd_go && cmd.op == isu_pkg::ISU_OP_ALU)
			acc_q <= acc_q + rd_val;
		else if (cmd_go && do_store && is_spec && loc_e == `ISU_A_ACC)
			acc_q <= wval;
	end

	// Table read result high byte
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			tres_q <= 8'h00;
		else if (cmd_go && cmd.op == isu_pkg::ISU_OP_TRD)
			tres_q <= TABLE_WORD[15:8];
		else if (cmd_go && do_store && is_spec && loc_e == `ISU_A_TRES)
			tres_q <= wval;
	end
	// pointers are plain cells that software loads and steps
	assign TABLE_ADDR = {mem_q[`ISU_A_TBHI], mem_q[`ISU_A_TBLO]};

	// Bank select: unimplemented bits read zero
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			bank_q <= `ISU_BANK_RST;
		else if (bank_wr)
			bank_q <= wval & bank_mask;
		else if (wr_go && aph_q.addr == `ISU_R_BANK)
			bank_q <= HWDATA[7:0] & bank_mask;
	end

	// Program counter: jump targets take the selected bank as their top bits
	localparam int OFS = PC_BITS - BB;
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			pc_q <= '0;
		else if (cmd_go && cmd.op == isu_pkg::ISU_OP_JMP)
			pc_q <= {bank_q[BB-1:0], HWDATA[OFS-1+8:8]};
		else if (pcl_wr)
			pc_q <= {pc_q[PC_BITS-1:8], wval};
		else if (cmd_go)
			pc_q <= pc_q + PC_BITS'(1);
	end
	assign PC_OUT = pc_q;

	// Dummy cycle after a PC low byte write; commands are ignored meanwhile
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			state_q <= isu_pkg::ISU_ST_IDLE;
		else
			case (state_q)
				isu_pkg::ISU_ST_IDLE: if (pcl_wr) state_q <= isu_pkg::ISU_ST_DUMMY;
				isu_pkg::ISU_ST_DUMMY: state_q <= isu_pkg::ISU_ST_IDLE;
				default: state_q <= isu_pkg::ISU_ST_IDLE;
			endcase
	end
	assign BUSY = (state_q == isu_pkg::ISU_ST_DUMMY);

	// Last read value latched for software
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			rdat_q <= 8'h00;
		else if (cmd_go && cmd.op != isu_pkg::ISU_OP_NOP)
			rdat_q <= (cmd.op == isu_pkg::ISU_OP_TRD) ? TABLE_WORD[7:0] : rd_val;
	end

	// Read data registered at the address phase; unmapped reads give zero
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			rdata_q <= 32'h00000000;
		else if (rd_go)
		begin
			if (HADDR[11:0] == `ISU_R_STAT)
				rdata_q <= {31'h00000000, BUSY};
			else if (HADDR[11:0] == `ISU_R_RDAT)
				rdata_q <= {24'h000000, rdat_q};
			else if (HADDR[11:0] == `ISU_R_PC)
				rdata_q <= 32'(pc_q);
			else if (HADDR[11:0] == `ISU_R_BANK)
				rdata_q <= {24'h000000, bank_q};
			else if (HADDR[11:0] == `ISU_R_MEMA)
				rdata_q <= {24'h000000, acc_q};
			else if (HADDR[11:0] == `ISU_R_TROM)
				rdata_q <= {16'h0000, TABLE_ADDR};
			else
				rdata_q <= 32'h00000000;
		end
	end
	assign HRDATA = rdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
endmodule
`default_nettype wire

//--- design/isu_defines.svh
/*
 Offsets, field positions, reset values and timing counts of the indirect addressing
 special function unit. Assumes inclusion by bare name from the design files.
*/
`ifndef ISU_DEFINES_SVH
`define ISU_DEFINES_SVH
// Data memory addresses of the special registers (sector-local, 8 bits)
`define ISU_A_IND0 8'h00
`define ISU_A_PTR0 8'h01
`define ISU_A_IND1 8'h02
`define ISU_A_PTR1L 8'h03
`define ISU_A_PTR1S 8'h04
`define ISU_A_ACC 8'h05
`define ISU_A_PCLB 8'h06
`define ISU_A_TBLO 8'h07
`define ISU_A_TBHI 8'h08
`define ISU_A_TRES 8'h09
`define ISU_A_IND2 8'h0A
`define ISU_A_PTR2L 8'h0B
`define ISU_A_PTR2S 8'h0C
`define ISU_A_BANK 8'h0D
// Special area spans addresses below this in every sector
`define ISU_SPECIAL_TOP 8'h0E
// Bank select fields
`define ISU_BANK4_MASK 8'h03
`define ISU_BANK2_MASK 8'h01
`define ISU_BANK_RST 8'h00
`define ISU_PTR_RST 8'h00
`define ISU_IND_READ 8'h00
// Dummy cycles after a program counter low byte write
`define ISU_PCL_DUMMY 2'h1
// AHB-Lite register map (byte addresses)
`define ISU_R_CMD 12'h000
`define ISU_R_STAT 12'h004
`define ISU_R_RDAT 12'h008
`define ISU_R_PC 12'h00C
`define ISU_R_BANK 12'h010
`define ISU_R_MEMA 12'h014
`define ISU_R_TROM 12'h018
// Command word fields
`define ISU_C_OP_LSB 28
`define ISU_C_ADDR_LSB 8
`define ISU_HTRANS_NONSEQ 2'h2
`endif

//--- design/isu_pkg.sv
/*
 Types of the indirect addressing special function unit.
 Sets its own opcode and state values; isu_defines.svh holds the other numeric constants.
*/
package isu_pkg;
	typedef enum logic [3:0] {
		ISU_OP_NOP = 4'h0,
		ISU_OP_RD = 4'h1,
		ISU_OP_WR = 4'h2,
		ISU_OP_INC = 4'h3,
		ISU_OP_DEC = 4'h4,
		ISU_OP_LRD = 4'h5,
		ISU_OP_LWR = 4'h6,
		ISU_OP_JMP = 4'h7,
		ISU_OP_TRD = 4'h8,
		ISU_OP_ALU = 4'h9
	} isu_op_t;
	typedef enum logic [1:0] {
		ISU_ST_IDLE = 2'h0,
		ISU_ST_DUMMY = 2'h1
	} isu_state_t;
	typedef struct packed {
		isu_op_t op;
		logic [11:0] rsv;
		logic [7:0] sector;
		logic [7:0] addr;
	} isu_cmd_t;
	typedef struct packed {
		logic [1:0] bus_ph;
		logic [11:0] addr;
		logic wr;
	} isu_aph_t;
endpackage

//--- verif/isu_monitor.sv
/*
 Port checker of isu_core.
 Assumes the register map and command layout of isu_defines.svh; bound at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isu_defines.svh"
module isu_monitor #(
	parameter int BANKS = 4,
	parameter int PC_BITS = 13
)(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic [PC_BITS-1:0] PC_OUT,
	input wire logic BUSY
);
	localparam int BB = (BANKS == 4) ? 2 : 1;
	logic cmd_q;
	logic rd_q;
	logic [11:0] a_q;
	wire logic sel = HSEL && HREADY && HTRANS == `ISU_HTRANS_NONSEQ;
	// Address phase kept so that the data phase can be judged
	always_ff @(posedge REF_CLK)
	begin
		cmd_q <= RST_N && sel && HWRITE && HADDR[11:0] == `ISU_R_CMD;
		rd_q <= RST_N && sel && !HWRITE;
		a_q <= HADDR[11:0];
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	sequence pcl_wr;
		cmd_q && !BUSY && HWDATA[31:28] == isu_pkg::ISU_OP_WR && HWDATA[15:0] == {8'h00, `ISU_A_PCLB};
	endsequence
	sequence jmp_wr;
		cmd_q && !BUSY && HWDATA[31:28] == isu_pkg::ISU_OP_JMP;
	endsequence
	chk_ready_okay: assert property (HREADYOUT && !HRESP)
		else $error("wait state or error response");
	chk_busy_single: assert property (BUSY |=> !BUSY)
		else $error("dummy cycle too long");
	chk_pcl_dummy: assert property (pcl_wr |=> BUSY)
		else $error("no dummy cycle");
	chk_pcl_page: assert property (pcl_wr |=> $stable(PC_OUT[PC_BITS-1:8]))
		else $error("page bits changed");
	chk_jmp_target: assert property (jmp_wr |=> PC_OUT[PC_BITS-BB-1:0] == $past(HWDATA[PC_BITS-BB+7:8]))
		else $error("jump target wrong");
	// Without a command the counter must not move, so stray jumps show up
	chk_pc_hold: assert property (!cmd_q |=> $stable(PC_OUT))
		else $error("pc moved");
	chk_bank_upper: assert property (rd_q && a_q == `ISU_R_BANK |-> HRDATA[31:BB] == '0)
		else $error("bank upper bits set");
	chk_unmapped_zero: assert property (rd_q && a_q >= 12'h01C |-> HRDATA == '0)
		else $error("unmapped read not zero");
endmodule
bind isu_core isu_monitor #(.BANKS(BANKS), .PC_BITS(PC_BITS)) i_isu_monitor (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
	.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PC_OUT(PC_OUT), .BUSY(BUSY));
`default_nettype wire

//--- verif/tb_isu_core.sv
/*
 Self-checking bench of isu_core: bus tasks and command sequences.
 Assumes the map of isu_defines.svh and a four-bank build.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isu_defines.svh"
module tb_isu_core;
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = '0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = '0;
	logic [15:0] TABLE_WORD = '0;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic [15:0] TABLE_ADDR;
	logic [31:0] rdat;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	isu_core #(.SECTORS(2), .BANKS(4), .PAGE_BITS(8), .PC_BITS(13)) i_isu_core (.REF_CLK(REF_CLK), .RST_N(RST_N),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(), .TABLE_ADDR(TABLE_ADDR),
		.TABLE_WORD(TABLE_WORD), .PC_OUT(), .BUSY());
	always #5 REF_CLK = ~REF_CLK;
	task automatic end_sim();
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Whole run needs a few hundred cycles
	always @(posedge REF_CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		HSEL <= 1'b1;
		HTRANS <= `ISU_HTRANS_NONSEQ;
		HADDR <= {20'h00000, a};
		HWRITE <= w;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		rdat = HRDATA;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, '0);
		check(rdat, exp);
	endtask
	task automatic cmd(input isu_pkg::isu_op_t op, input logic [7:0] loc, input logic [7:0] sec = 8'h00);
		bus(1'b1, `ISU_R_CMD, {op, 12'h000, sec, loc});
	endtask
	task automatic acc_is(input logic [7:0] v);
		rd(`ISU_R_MEMA, {24'h000000, v});
	endtask
	// Table read is the only way to bring a constant into memory
	task automatic poke(input logic [7:0] loc, input logic [7:0] v);
		TABLE_WORD <= {8'hC3, v};
		cmd(isu_pkg::ISU_OP_TRD, loc);
	endtask
	task automatic setp(input logic [7:0] loc, input logic [7:0] v);
		poke(8'h20, v);
		cmd(isu_pkg::ISU_OP_RD, 8'h20);
		cmd(isu_pkg::ISU_OP_WR, loc);
	endtask
	initial
	begin
		repeat (2) @(posedge REF_CLK);
		RST_N <= 1'b1;
		rd(`ISU_R_BANK, 32'h0);
		rd(`ISU_R_PC, 32'h0);
		bus(1'b1, `ISU_R_BANK, 32'hFF);
		rd(`ISU_R_BANK, 32'h3);
		rd(12'h040, 32'h0);
		setp(`ISU_A_PTR0, 8'h30);
		poke(8'h30, 8'h77);
		cmd(isu_pkg::ISU_OP_INC, `ISU_A_IND0);
		cmd(isu_pkg::ISU_OP_RD, 8'h30);
		acc_is(8'h78);
		cmd(isu_pkg::ISU_OP_INC, `ISU_A_PTR0);
		cmd(isu_pkg::ISU_OP_RD, `ISU_A_PTR0);
		acc_is(8'h31);
		setp(`ISU_A_PTR0, `ISU_A_IND1);
		cmd(isu_pkg::ISU_OP_RD, `ISU_A_IND0);
		acc_is(8'h00);
		poke(8'hF0, 8'h11);
		poke(8'h24, 8'h3C);
		cmd(isu_pkg::ISU_OP_RD, 8'h24);
		cmd(isu_pkg::ISU_OP_LWR, 8'hF0, 8'h01);
		setp(`ISU_A_PTR1L, 8'hF0);
		setp(`ISU_A_PTR1S, 8'h01);
		cmd(isu_pkg::ISU_OP_RD, `ISU_A_IND1);
		acc_is(8'h3C);
		cmd(isu_pkg::ISU_OP_LRD, 8'hF0);
		acc_is(8'h11);
		setp(`ISU_A_PTR2L, 8'hF0);
		setp(`ISU_A_PTR2S, 8'h01);
		cmd(isu_pkg::ISU_OP_DEC, `ISU_A_IND2);
		cmd(isu_pkg::ISU_OP_LRD, 8'hF0, 8'h01);
		acc_is(8'h3B);
		cmd(isu_pkg::ISU_OP_ALU, 8'hF0);
		acc_is(8'h4C);
		setp(`ISU_A_TBLO, 8'h34);
		setp(`ISU_A_TBHI, 8'h12);
		// Pointer cells update on the edge that ends the command, so look half a cycle later
		@(negedge REF_CLK);
		check({16'h0000, TABLE_ADDR}, 32'h1234);
		cmd(isu_pkg::ISU_OP_INC, `ISU_A_TBLO);
		@(negedge REF_CLK);
		check({16'h0000, TABLE_ADDR}, 32'h1235);
		poke(8'h26, 8'h5C);
		cmd(isu_pkg::ISU_OP_RD, 8'h26);
		acc_is(8'h5C);
		cmd(isu_pkg::ISU_OP_RD, `ISU_A_TRES);
		acc_is(8'hC3);
		bus(1'b1, `ISU_R_CMD, {isu_pkg::ISU_OP_JMP, 9'h000, 11'h123, 8'h00});
		rd(`ISU_R_PC, 32'h1923);
		bus(1'b1, `ISU_R_BANK, 32'h1);
		bus(1'b1, `ISU_R_CMD, {isu_pkg::ISU_OP_JMP, 9'h000, 11'h045, 8'h00});
		rd(`ISU_R_PC, 32'h0845);
		poke(8'h27, 8'h5A);
		cmd(isu_pkg::ISU_OP_RD, 8'h27);
		cmd(isu_pkg::ISU_OP_WR, `ISU_A_PCLB);
		rd(`ISU_R_PC, 32'h085A);
		rd(`ISU_R_STAT, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
